// >>> common/dpm_params.svh
// constants for the mid-range diffserv priority map bank
`ifndef DPM_PARAMS_SVH
`define DPM_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define DPM_OFS_MAP_4 8'h64
`define DPM_OFS_MAP_5 8'h65
`define DPM_OFS_MAP_6 8'h66
`define DPM_OFS_MAP_7 8'h67
`define DPM_OFS_MAP_8 8'h68
`define DPM_OFS_MAP_9 8'h69
`define DPM_OFS_MAP_10 8'h6a
`define DPM_OFS_MAP_11 8'h6b
`define DPM_OFS_MAP_12 8'h6c

// ****************************************************************
// bank geometry and reset value
// ****************************************************************
`define DPM_NUM_REGS 9
`define DPM_REG_W 8
`define DPM_ADDR_W 8
`define DPM_IDX_W 4
`define DPM_RESET_VAL 8'h00
`define DPM_FIELD_W 2
`define DPM_FIELD_RESET 2'h0
`define DPM_FIELD_SEL_W 2
`define DPM_FIELDS_PER_REG 4

// ****************************************************************
// code fields
// ****************************************************************
`define DPM_TOS_W 8
`define DPM_CODE_W 6
`define DPM_CODE_MSB 7
`define DPM_CODE_LSB 2
`define DPM_CODE_FIRST 6'h10
`define DPM_CODE_LAST 6'h33
`define DPM_CODE_SPAN_W 6
`define DPM_NUM_CODES 64

`endif

// >>> common/dpm_pkg.sv
// types shared by the diffserv priority map bank
`default_nettype none
`include "dpm_params.svh"

package dpm_pkg;

    // register access request from the management port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`DPM_ADDR_W-1:0] addr;
        logic [`DPM_REG_W-1:0] wdata;
    } dpm_reg_req_type;

    // register access answer
    typedef struct packed {
        logic ack;
        logic hit;
        logic [`DPM_REG_W-1:0] rdata;
    } dpm_reg_rsp_type;

    // priority lookup request from the frame parser
    typedef struct packed {
        logic valid;
        logic [`DPM_TOS_W-1:0] tos;
    } dpm_lkp_req_type;

    // priority lookup answer to the queueing logic
    typedef struct packed {
        logic valid;
        logic hit;
        logic [`DPM_CODE_W-1:0] code;
        logic [`DPM_FIELD_W-1:0] prio;
    } dpm_lkp_rsp_type;

endpackage
`default_nettype wire

// >>> hdl/dpm_map_mem.sv
// storage for the priority map words, registered read port
`timescale 1ns/1ps
`default_nettype none
`include "dpm_params.svh"

module dpm_map_mem #(
    parameter int NUM_REGS = `DPM_NUM_REGS,
    parameter int DATA_W = `DPM_REG_W,
    parameter int IDX_W = `DPM_IDX_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // write port
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [DATA_W-1:0] wr_data,
    // read port, data one cycle after rd_en, zero after any other cycle
    input wire logic rd_en,
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [DATA_W-1:0] rd_data,
    // whole table, lowest word in the low bits
    output logic [NUM_REGS*DATA_W-1:0] table_flat
);

    logic [DATA_W-1:0] mem_r [NUM_REGS];

    // ****************************************************************
    // storage
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                mem_r[i] <= DATA_W'(`DPM_RESET_VAL);
            end
        end else if (wr_en && (int'(wr_idx) < NUM_REGS)) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    // a read in the same cycle as a write to the same word sees the old value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= DATA_W'(`DPM_RESET_VAL);
        end else if (rd_en) begin
            if (int'(rd_idx) < NUM_REGS) begin
                rd_data <= mem_r[rd_idx];
            end else begin
                rd_data <= DATA_W'(`DPM_RESET_VAL);
            end
        end else begin
            rd_data <= DATA_W'(`DPM_RESET_VAL);
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            table_flat[i*DATA_W +: DATA_W] = mem_r[i];
        end
    end

endmodule
`default_nettype wire

// >>> hdl/dpm_prio_map.sv
// diffserv priority map bank for codes 0x10 to 0x33 with its lookup path
`timescale 1ns/1ps
`default_nettype none
`include "dpm_params.svh"

module dpm_prio_map #(
    parameter int NUM_REGS = `DPM_NUM_REGS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // management register port
    input wire dpm_pkg::dpm_reg_req_type reg_req,
    output dpm_pkg::dpm_reg_rsp_type reg_rsp,
    // frame lookup
    input wire dpm_pkg::dpm_lkp_req_type lkp_req,
    output dpm_pkg::dpm_lkp_rsp_type lkp_rsp
);

    localparam int IDX_W = `DPM_IDX_W;
    localparam int REG_W = `DPM_REG_W;
    localparam int FLD_W = `DPM_FIELD_W;
    localparam int SEL_W = `DPM_FIELD_SEL_W;
    localparam int CODE_W = `DPM_CODE_W;
    localparam int NUM_CODES = `DPM_NUM_CODES;
    localparam int PER_REG = `DPM_FIELDS_PER_REG;

    // ****************************************************************
    // helper functions
    // ****************************************************************

    // address decode shared by the read and write paths
    function automatic logic addr_mapped(input logic [`DPM_ADDR_W-1:0] addr);
        logic ok;
        ok = 1'b0;
        if (addr == `DPM_OFS_MAP_4) begin
            ok = 1'b1;
        end else if (addr == `DPM_OFS_MAP_5) begin
            ok = 1'b1;
        end else if (addr == `DPM_OFS_MAP_6) begin
            ok = 1'b1;
        end else if (addr == `DPM_OFS_MAP_7) begin
            ok = 1'b1;
        end else if (addr == `DPM_OFS_MAP_8) begin
            ok = 1'b1;
        end else if (addr == `DPM_OFS_MAP_9) begin
            ok = 1'b1;
        end else if (addr == `DPM_OFS_MAP_10) begin
            ok = 1'b1;
        end else if (addr == `DPM_OFS_MAP_11) begin
            ok = 1'b1;
        end else if (addr == `DPM_OFS_MAP_12) begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    // word index within the bank; only meaningful when the address is mapped
    function automatic logic [IDX_W-1:0] addr_index(input logic [`DPM_ADDR_W-1:0] addr);
        logic [IDX_W-1:0] idx;
        idx = '0;
        if (addr == `DPM_OFS_MAP_4) begin
            idx = IDX_W'(`DPM_OFS_MAP_4 - `DPM_OFS_MAP_4);
        end else if (addr == `DPM_OFS_MAP_5) begin
            idx = IDX_W'(`DPM_OFS_MAP_5 - `DPM_OFS_MAP_4);
        end else if (addr == `DPM_OFS_MAP_6) begin
            idx = IDX_W'(`DPM_OFS_MAP_6 - `DPM_OFS_MAP_4);
        end else if (addr == `DPM_OFS_MAP_7) begin
            idx = IDX_W'(`DPM_OFS_MAP_7 - `DPM_OFS_MAP_4);
        end else if (addr == `DPM_OFS_MAP_8) begin
            idx = IDX_W'(`DPM_OFS_MAP_8 - `DPM_OFS_MAP_4);
        end else if (addr == `DPM_OFS_MAP_9) begin
            idx = IDX_W'(`DPM_OFS_MAP_9 - `DPM_OFS_MAP_4);
        end else if (addr == `DPM_OFS_MAP_10) begin
            idx = IDX_W'(`DPM_OFS_MAP_10 - `DPM_OFS_MAP_4);
        end else if (addr == `DPM_OFS_MAP_11) begin
            idx = IDX_W'(`DPM_OFS_MAP_11 - `DPM_OFS_MAP_4);
        end else if (addr == `DPM_OFS_MAP_12) begin
            idx = IDX_W'(`DPM_OFS_MAP_12 - `DPM_OFS_MAP_4);
        end
        return idx;
    endfunction

    // code lies inside the span this bank holds
    function automatic logic code_in_span(input logic [`DPM_CODE_W-1:0] code);
        return (code >= `DPM_CODE_FIRST) && (code <= `DPM_CODE_LAST);
    endfunction

    // pull the code out of a tos / traffic class byte
    function automatic logic [`DPM_CODE_W-1:0] tos_code(input logic [`DPM_TOS_W-1:0] tos);
        return tos[`DPM_CODE_MSB:`DPM_CODE_LSB];
    endfunction

    // one-hot decode of a code over every position of the full table
    function automatic logic [NUM_CODES-1:0] code_onehot(input logic [CODE_W-1:0] code);
        logic [NUM_CODES-1:0] sel;
        sel = '0;
        sel[code] = 1'b1;
        return sel;
    endfunction

    // field in a given slot of a word, lowest slot in bits 1-0
    function automatic logic [FLD_W-1:0] word_field(
        input logic [REG_W-1:0] word,
        input logic [SEL_W-1:0] slot
    );
        return word[int'(slot)*FLD_W +: FLD_W];
    endfunction

    // code has a field in the words this bank builds
    function automatic logic code_held(input logic [CODE_W-1:0] code);
        logic [CODE_W-1:0] rel;
        rel = code - `DPM_CODE_FIRST;
        return code_in_span(code) && (int'(rel) < NUM_REGS * PER_REG);
    endfunction

    // ****************************************************************
    // register port decode
    // ****************************************************************
    logic req_mapped;
    logic [IDX_W-1:0] req_idx;
    logic mem_wr_en;
    logic mem_rd_en;

    always_comb begin
        req_mapped = addr_mapped(reg_req.addr);
        req_idx = addr_index(reg_req.addr);
        // writes to unmapped offsets are dropped so neighbouring blocks stay untouched
        mem_wr_en = reg_req.wr && req_mapped;
        mem_rd_en = reg_req.rd && req_mapped;
    end

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [REG_W-1:0] mem_rd_data;
    logic [NUM_REGS*REG_W-1:0] table_flat;

    dpm_map_mem #(
        .NUM_REGS(NUM_REGS),
        .DATA_W(REG_W),
        .IDX_W(IDX_W)
    ) u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(mem_wr_en),
        .wr_idx(req_idx),
        .wr_data(reg_req.wdata),
        .rd_en(mem_rd_en),
        .rd_idx(req_idx),
        .rd_data(mem_rd_data),
        .table_flat(table_flat)
    );

    // ****************************************************************
    // register port answer
    // ****************************************************************
    logic ack_r;
    logic ack_nxt;
    logic hit_r;
    logic hit_nxt;

    // every access is answered one cycle later, mapped or not, so the
    // management side never waits on a missing decode
    always_comb begin
        ack_nxt = reg_req.wr || reg_req.rd;
        hit_nxt = ack_nxt && req_mapped;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hit_r <= 1'b0;
        end else begin
            hit_r <= hit_nxt;
        end
    end

    // read data come straight from the storage register, which holds zero
    // after every cycle without a mapped read
    always_comb begin
        reg_rsp.ack = ack_r;
        reg_rsp.hit = hit_r;
        reg_rsp.rdata = mem_rd_data;
    end

    // ****************************************************************
    // lookup path
    // ****************************************************************
    logic [CODE_W-1:0] lkp_code;
    logic [NUM_CODES-1:0] lkp_sel;
    logic lkp_hit;
    logic [FLD_W-1:0] lkp_prio;
    logic [FLD_W-1:0] code_prio [NUM_CODES];

    // each word gives four fields in code order, so a code's field lands at
    // twice its offset from the first code of the bank
    always_comb begin
        for (int c = 0; c < NUM_CODES; c++) begin
            code_prio[c] = `DPM_FIELD_RESET;
        end
        for (int w = 0; w < NUM_REGS; w++) begin
            for (int s = 0; s < PER_REG; s++) begin
                if (int'(`DPM_CODE_FIRST) + (w * PER_REG) + s < NUM_CODES) begin
                    code_prio[int'(`DPM_CODE_FIRST) + (w * PER_REG) + s] =
                        word_field(table_flat[w*REG_W +: REG_W], SEL_W'(s));
                end
            end
        end
    end

    // the code is decoded one-hot over the whole table and the field gathered
    // by and-or, so no wide index arithmetic sits on the frame path
    always_comb begin
        lkp_code = tos_code(lkp_req.tos);
        lkp_sel = code_onehot(lkp_code);
        lkp_hit = code_held(lkp_code);
        // codes held by the neighbouring words see zero here
        lkp_prio = `DPM_FIELD_RESET;
        for (int c = 0; c < NUM_CODES; c++) begin
            if (lkp_sel[c]) begin
                lkp_prio = lkp_prio | code_prio[c];
            end
        end
    end

    logic lkp_valid_r;
    logic lkp_hit_r;
    logic [CODE_W-1:0] lkp_code_r;
    logic [CODE_W-1:0] lkp_code_nxt;
    logic [FLD_W-1:0] lkp_prio_r;
    logic [FLD_W-1:0] lkp_prio_nxt;

    // code and priority hold between requests; table writes in the taking
    // cycle are not yet visible to the lookup
    always_comb begin
        lkp_code_nxt = lkp_code_r;
        lkp_prio_nxt = lkp_prio_r;
        if (lkp_req.valid) begin
            lkp_code_nxt = lkp_code;
            lkp_prio_nxt = lkp_prio;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lkp_valid_r <= 1'b0;
        end else begin
            lkp_valid_r <= lkp_req.valid;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lkp_hit_r <= 1'b0;
        end else begin
            lkp_hit_r <= lkp_req.valid && lkp_hit;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lkp_code_r <= '0;
        end else begin
            lkp_code_r <= lkp_code_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lkp_prio_r <= `DPM_FIELD_RESET;
        end else begin
            lkp_prio_r <= lkp_prio_nxt;
        end
    end

    // the answer reaches the queueing logic one cycle after the request
    always_comb begin
        lkp_rsp.valid = lkp_valid_r;
        lkp_rsp.hit = lkp_hit_r;
        lkp_rsp.code = lkp_code_r;
        lkp_rsp.prio = lkp_prio_r;
    end

endmodule
`default_nettype wire

// >>> test/dpm_prio_map_properties.sv
// port assertions for the priority map bank
`timescale 1ns/1ps
`default_nettype none
`include "dpm_params.svh"
module dpm_prio_map_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire dpm_pkg::dpm_reg_req_type reg_req,
    input wire dpm_pkg::dpm_reg_rsp_type reg_rsp,
    input wire dpm_pkg::dpm_lkp_req_type lkp_req,
    input wire dpm_pkg::dpm_lkp_rsp_type lkp_rsp
);
    // ****************************************************************
    // answer timing
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic acc;
    logic map;
    logic lhit;
    logic [5:0] code;
    assign acc = reg_req.wr | reg_req.rd;
    assign map = reg_req.addr inside {[8'h64:8'h6c]};
    assign code = lkp_req.tos[7:2];
    assign lhit = code inside {[6'h10:6'h33]};
    ack_pulse_a: assert property (acc |=> reg_rsp.ack) else $error("ack missing");
    ack_idle_a: assert property (!acc |=> !reg_rsp.ack) else $error("stray ack");
    map_hit_a: assert property (acc && map |=> reg_rsp.hit) else $error("hit lost");
    unmapped_zero_a: assert property (acc && !map |=> !reg_rsp.hit && reg_rsp.rdata == 8'h00)
        else $error("unmapped answer");
    lkp_answer_a: assert property (lkp_req.valid |=> lkp_rsp.valid && lkp_rsp.code == $past(code))
        else $error("lookup answer");
    lkp_hold_a: assert property (!lkp_req.valid |=> !lkp_rsp.valid
        && $stable(lkp_rsp.prio) && $stable(lkp_rsp.code)) else $error("lookup hold");
    lkp_range_a: assert property (lkp_req.valid |=> lkp_rsp.hit == $past(lhit))
        else $error("lookup range");
    miss_prio_a: assert property (lkp_req.valid && !lhit |=> lkp_rsp.prio == 2'h0)
        else $error("miss prio");
    cover property (reg_req.wr && map);
    cover property (reg_req.wr && reg_req.rd && map);
    cover property (lkp_req.valid && lhit);
endmodule
`default_nettype wire

// >>> test/dpm_prio_map_tb_top.sv
// self-checking bench for the priority map bank
`timescale 1ns/1ps
`default_nettype none
`include "dpm_params.svh"
module dpm_prio_map_tb_top;
    // ****************************************************************
    // harness
    // ****************************************************************
    logic clk;
    logic rst_n;
    dpm_pkg::dpm_reg_req_type reg_req;
    dpm_pkg::dpm_reg_rsp_type reg_rsp;
    dpm_pkg::dpm_lkp_req_type lkp_req;
    dpm_pkg::dpm_lkp_rsp_type lkp_rsp;
    logic [7:0] words[9];
    logic [8:0] reg_q[$];
    logic [8:0] lkp_q[$];
    logic [31:0] lfsr;
    int mismatches;
    int checks_done;
    int cycles = 0;

    dpm_prio_map i_dut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .lkp_req(lkp_req), .lkp_rsp(lkp_rsp));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic compare(input logic [8:0] got, input logic [8:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one request cycle; notes are taken from the table before the taking edge,
    // so a read beside a write of the same word expects the old value
    task automatic drive(input logic wr, input logic rd, input logic [7:0] addr,
        input logic [7:0] wd, input logic lv, input logic [7:0] tos);
        logic [5:0] off;
        logic m;
        off = tos[7:2] - 6'h10;
        m = addr inside {[8'h64:8'h6c]};
        @(posedge clk);
        #1;
        reg_req = {wr, rd, addr, wd};
        lkp_req = {lv, tos};
        if (lv) begin
            lkp_q.push_back(tos[7:2] inside {[6'h10:6'h33]}
                ? {1'b1, tos[7:2], words[off[5:2]][2 * off[1:0] +: 2]} : {1'b0, tos[7:2], 2'h0});
        end
        if (wr | rd) begin
            reg_q.push_back({m, (rd && m) ? words[addr - 8'h64] : 8'h00});
        end
        if (wr && m) begin
            words[addr - 8'h64] = wd;
        end
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        words = '{default: 8'h00};
        repeat (4) @(posedge clk);
        compare({reg_rsp.ack, reg_rsp.hit, lkp_rsp.valid, lkp_rsp.code}, 9'h000, "reset");
        #1;
        rst_n = 1'b1;
    endtask

    // reads every word while looking up all 64 codes
    task automatic sweep();
        for (int i = 0; i < 64; i++) begin
            lfsr = next_rand(lfsr);
            drive(1'b0, i < 9, 8'h64 + 8'(i), 8'h00, 1'b1, {6'(i), lfsr[1:0]});
        end
        drive(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00);
    endtask

    always @(negedge clk) begin
        if (reg_rsp.ack === 1'b1) begin
            compare({reg_rsp.hit, reg_rsp.rdata}, reg_q.pop_front(), "reg");
        end
        if (lkp_rsp.valid === 1'b1) begin
            compare({lkp_rsp.hit, lkp_rsp.code, lkp_rsp.prio}, lkp_q.pop_front(), "lkp");
        end
    end

    // the whole run is about 520 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        reg_req = '0;
        lkp_req = '0;
        lfsr = 32'hc120eb92;
        mismatches = 0;
        checks_done = 0;
        do_reset();
        sweep();
        $display("reset values done");
        for (int i = 0; i < 9; i++) begin
            drive(1'b1, 1'b0, 8'h64 + 8'(i), 8'h1b + 8'(i * 29), 1'b0, 8'h00);
        end
        sweep();
        $display("field placement done");
        for (int i = 0; i < 300; i++) begin
            lfsr = next_rand(lfsr);
            drive(lfsr[0], lfsr[1], 8'h60 + 8'(lfsr[5:2]), lfsr[13:6], lfsr[14], lfsr[22:15]);
        end
        drive(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00);
        $display("random traffic done");
        repeat (2) @(posedge clk);
        do_reset();
        sweep();
        $display("second reset done");
        repeat (3) @(posedge clk);
        compare(9'(reg_q.size() + lkp_q.size()), 9'h000, "unanswered");
        give_verdict();
    end
endmodule

bind dpm_prio_map dpm_prio_map_properties i_props (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rsp(reg_rsp), .lkp_req(lkp_req), .lkp_rsp(lkp_rsp));
`default_nettype wire
